// file: rtl/aipc_mic_capture.sv
`timescale 1ns/1ns
module aipc_mic_capture (
  input wire logic clk_i, // system clock
  input wire logic rst_n_i, // async reset, active low
  input wire logic mic_clk_i, // microphone bit clock, sampled
  input wire logic mic_data_i, // shared microphone data
  input wire logic swap_i, // exchange left and right
  input wire logic pol_i, // one-is-positive when set
  output logic left_bit_o, // left bit, one means positive
  output logic left_valid_o, // left bit strobe
  output logic right_bit_o, // right bit, one means positive
  output logic right_valid_o // right bit strobe
);
  logic mclk_q;
  logic rise;
  logic fall;
  logic norm_bit;

  assign rise = mic_clk_i & ~mclk_q;
  assign fall = ~mic_clk_i & mclk_q;
  // normalise so downstream always sees one as positive
  assign norm_bit = pol_i ? mic_data_i : ~mic_data_i;

  // edge history of the microphone clock
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      mclk_q <= 1'b0;
    else
      mclk_q <= mic_clk_i;
  end

  // rising edge is left unless swapped, falling edge the other
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      left_bit_o <= 1'b0;
      right_bit_o <= 1'b0;
      left_valid_o <= 1'b0;
      right_valid_o <= 1'b0;
    end
    else
    begin
      left_valid_o <= (rise & ~swap_i) | (fall & swap_i);
      right_valid_o <= (fall & ~swap_i) | (rise & swap_i);
      if ((rise & ~swap_i) | (fall & swap_i))
        left_bit_o <= norm_bit;
      if ((fall & ~swap_i) | (rise & swap_i))
        right_bit_o <= norm_bit;
    end
  end
endmodule

// file: rtl/aipc_pkg.sv
package aipc_pkg;

  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_PAIR23_CTRL = 8'h1e;
  localparam logic [7:0] IDX_CH0_VOL = 8'h1f;
  localparam logic [7:0] IDX_CH1_VOL = 8'h20;
  localparam logic [7:0] IDX_CH2_VOL = 8'h21;
  localparam logic [7:0] IDX_CH3_VOL = 8'h22;
  localparam logic [7:0] IDX_AMP0_CTRL = 8'h23;
  localparam logic [7:0] IDX_DECIM_PWR = 8'h30;
  localparam logic [7:0] IDX_STATUS = 8'h31;
  localparam logic [7:0] IDX_LIVE_VOL0 = 8'h32;
  localparam logic [7:0] IDX_LIVE_VOL3 = 8'h35;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_PAIR23_CTRL = 8'h00;
  localparam logic [7:0] RST_VOL = 8'h00;
  localparam logic [7:0] RST_AMP0_CTRL = 8'h40;
  localparam logic [7:0] RST_DECIM_PWR = 8'h00;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int unsigned BIT_ADC2_EN = 0;
  localparam int unsigned BIT_ADC3_EN = 1;
  localparam int unsigned BIT_DEC_SRC = 2;
  localparam int unsigned BIT_MIC_SWAP = 3;
  localparam int unsigned BIT_MIC_POL = 4;
  localparam int unsigned HPF_LSB = 5;
  localparam int unsigned BIT_AMP_MUTE = 6;
  localparam int unsigned BIT_AMP_MIC = 7;
  localparam int unsigned SINC2_BIT = 2;
  localparam int unsigned SINC3_BIT = 3;

  // ---------------------------------------------------------------
  // timing and scale
  // ---------------------------------------------------------------
  localparam logic [3:0] RAMP_LAST_SAMPLE = 4'(16 - 1);
  localparam logic [3:0] AMP_SLEW_LAST_SAMPLE = 4'(16 - 1);
  localparam logic [7:0] VOL_FULL_ATTEN = 8'hff;
  localparam logic [1:0] HPF_OFF = 2'h0;
  localparam logic [9:0] VOL_STEP_EIGHTH_DB = 10'h003;
  localparam logic signed [8:0] GAIN_MIN_QDB = -9'sd48;
  localparam logic signed [8:0] GAIN_STEP_QDB = 9'sd3;

  typedef enum logic [1:0] {RAMP_OFF, RAMP_RUN, RAMP_SETTLED} aipc_ramp_state_type;

  // attenuation in eighths of a dB for a volume code
  function automatic logic [9:0] vol_att_eighth_db(input logic [7:0] code);
    return VOL_STEP_EIGHTH_DB * {2'b00, code};
  endfunction

  // amplifier gain in quarters of a dB for a gain code
  function automatic logic signed [8:0] amp_gain_qdb(input logic [5:0] code);
    return GAIN_MIN_QDB + GAIN_STEP_QDB * $signed({3'b000, code});
  endfunction

endpackage

// file: rtl/aipc_top.sv
`timescale 1ns/1ns
module aipc_top (
  input wire logic clk_i, // system clock, 100 MHz
  input wire logic rst_n_i, // async reset, active low
  input wire logic hsel_i, // slave select
  input wire logic [31:0] haddr_i, // byte address
  input wire logic [1:0] htrans_i, // transfer type
  input wire logic hwrite_i, // write when high
  input wire logic [2:0] hsize_i, // transfer size
  input wire logic [31:0] hwdata_i, // write data
  input wire logic hready_i, // bus ready
  output logic [31:0] hrdata_o, // read data
  output logic hreadyout_o, // slave ready
  output logic hresp_o, // always okay
  input wire logic sample_tick_i, // one pulse per sample period
  input wire logic mic_clk_i, // microphone bit clock
  input wire logic mic_data_i, // microphone data
  input wire logic adc_mod_valid_i, // converter bit strobe
  input wire logic adc2_mod_i, // converter 2 modulator bit
  input wire logic adc3_mod_i, // converter 3 modulator bit
  output logic dec2_bit_o, // decimator 2 input bit
  output logic dec2_valid_o, // decimator 2 bit strobe
  output logic dec3_bit_o, // decimator 3 input bit
  output logic dec3_valid_o, // decimator 3 bit strobe
  output logic adc2_power_o, // converter 2 fully enabled
  output logic adc3_power_o, // converter 3 fully enabled
  output logic [3:0] sinc_en_o, // decimator sinc enables
  output logic hpf_on_o, // high-pass filter in path
  output logic [1:0] hpf_corner_o, // corner: 1, 4, 8 Hz
  output logic [3:0][7:0] ch_volume_o, // live volume codes
  output logic [3:0][9:0] ch_atten_o, // live attenuation, 1/8 dB
  output logic amp0_power_o, // amplifier 0 powered
  output logic amp0_mute_o, // amplifier 0 muted
  output logic [5:0] amp0_gain_code_o, // applied gain code
  output logic signed [8:0] amp0_gain_qdb_o // applied gain, 1/4 dB
);
  import aipc_pkg::*;

  // ---------------------------------------------------------------
  // register storage
  // ---------------------------------------------------------------
  logic [7:0] pair23_q;
  logic [3:0][7:0] vol_q;
  logic [7:0] amp0_q;
  logic [7:0] decim_pwr_q;

  // ---------------------------------------------------------------
  // bus slave state
  // ---------------------------------------------------------------
  logic addr_take;
  logic wr_pend_q;
  logic rd_pend_q;
  logic [7:0] idx_q;
  logic map_ok_q;
  logic [7:0] rd_byte;
  logic hready_q;
  logic [31:0] hrdata_q;

  // ---------------------------------------------------------------
  // datapath
  // ---------------------------------------------------------------
  logic [3:0][7:0] live_vol;
  logic [3:0] ramping;
  logic mic_l_bit;
  logic mic_l_vld;
  logic mic_r_bit;
  logic mic_r_vld;
  logic adc2_pwr_q;
  logic adc3_pwr_q;
  logic [3:0] sinc_q;
  logic hpf_on_q;
  logic [1:0] hpf_corner_q;
  logic [3:0][9:0] atten_q;
  logic [5:0] amp_eff_q;
  logic [3:0] amp_div_q;
  logic amp_slewing;
  logic amp_step;
  logic amp_power_q;
  logic amp_mute_q;
  logic signed [8:0] amp_qdb_q;
  logic dec2_bit_q;
  logic dec2_vld_q;
  logic dec3_bit_q;
  logic dec3_vld_q;

  // an address phase is taken only for a live transfer on a ready bus
  assign addr_take = hsel_i & htrans_i[1] & hready_i;

  // ---------------------------------------------------------------
  // bus address and data phases
  // ---------------------------------------------------------------

  // whole-word accesses with empty upper address bits are mapped;
  // anything else is accepted, writes dropped, reads return zero
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      idx_q <= 8'h00;
      map_ok_q <= 1'b0;
    end
    else
    begin
      wr_pend_q <= addr_take & hwrite_i;
      rd_pend_q <= addr_take & ~hwrite_i;
      if (addr_take)
      begin
        idx_q <= haddr_i[9:2];
        map_ok_q <= (haddr_i[31:10] == 22'h00_0000) && (hsize_i == 3'h2);
      end
    end
  end

  // reads take one wait state so a write just before is always seen
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      hready_q <= 1'b1;
    else
      hready_q <= ~(addr_take & ~hwrite_i);
  end

  // read data is latched in the wait state from the stored registers
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      hrdata_q <= 32'h0000_0000;
    else if (rd_pend_q)
      hrdata_q <= {24'h00_0000, map_ok_q ? rd_byte : 8'h00};
  end

  // read decode; narrow registers sit in the low byte
  always_comb
  begin
    rd_byte = 8'h00;
    case (idx_q)
      IDX_PAIR23_CTRL: rd_byte = pair23_q;
      IDX_AMP0_CTRL: rd_byte = amp0_q;
      IDX_DECIM_PWR: rd_byte = decim_pwr_q;
      IDX_STATUS: rd_byte = {1'b0, amp_slewing, adc3_pwr_q, adc2_pwr_q, ramping};
      default:
      begin
        if (idx_q >= IDX_CH0_VOL && idx_q <= IDX_CH3_VOL)
          rd_byte = vol_q[2'(idx_q - IDX_CH0_VOL)];
        else if (idx_q >= IDX_LIVE_VOL0 && idx_q <= IDX_LIVE_VOL3)
          rd_byte = live_vol[2'(idx_q - IDX_LIVE_VOL0)];
      end
    endcase
  end

  assign hrdata_o = hrdata_q;
  assign hreadyout_o = hready_q;
  assign hresp_o = 1'b0;

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------

  // pair 2/3 control, all eight bits stored, reserved bit included
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      pair23_q <= RST_PAIR23_CTRL;
    else if (wr_pend_q && map_ok_q && idx_q == IDX_PAIR23_CTRL)
      pair23_q <= hwdata_i[7:0];
  end

  // amplifier 0 control; comes out of reset muted
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      amp0_q <= RST_AMP0_CTRL;
    else if (wr_pend_q && map_ok_q && idx_q == IDX_AMP0_CTRL)
      amp0_q <= hwdata_i[7:0];
  end

  // decimator power register holding the sinc enables
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      decim_pwr_q <= RST_DECIM_PWR;
    else if (wr_pend_q && map_ok_q && idx_q == IDX_DECIM_PWR)
      decim_pwr_q <= hwdata_i[7:0];
  end

  // ---------------------------------------------------------------
  // per-channel volume: register, ramp, attenuation
  // ---------------------------------------------------------------
  for (genvar ch = 0; ch < 4; ch++)
  begin : g_chan
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
      if (!rst_n_i)
        vol_q[ch] <= RST_VOL;
      else if (wr_pend_q && map_ok_q && idx_q == IDX_CH0_VOL + 8'(ch))
        vol_q[ch] <= hwdata_i[7:0];
    end

    aipc_vol_ramp u_ramp (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .sinc_en_i(decim_pwr_q[ch]),
      .sample_tick_i(sample_tick_i),
      .target_i(vol_q[ch]),
      .vol_o(live_vol[ch]),
      .ramping_o(ramping[ch])
    );

    // attenuation figure follows the live, ramped code
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
      if (!rst_n_i)
        atten_q[ch] <= 10'h000;
      else
        atten_q[ch] <= vol_att_eighth_db(live_vol[ch]);
    end
  end

  assign ch_volume_o = live_vol;
  assign ch_atten_o = atten_q;

  // ---------------------------------------------------------------
  // converter enables and filter setting
  // ---------------------------------------------------------------

  // a converter runs only when its own bit and its sinc agree
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      adc2_pwr_q <= 1'b0;
      adc3_pwr_q <= 1'b0;
      sinc_q <= 4'h0;
      hpf_on_q <= 1'b0;
      hpf_corner_q <= HPF_OFF;
    end
    else
    begin
      adc2_pwr_q <= pair23_q[BIT_ADC2_EN] & decim_pwr_q[SINC2_BIT];
      adc3_pwr_q <= pair23_q[BIT_ADC3_EN] & decim_pwr_q[SINC3_BIT];
      sinc_q <= decim_pwr_q[3:0];
      hpf_on_q <= pair23_q[HPF_LSB +: 2] != HPF_OFF;
      hpf_corner_q <= pair23_q[HPF_LSB +: 2];
    end
  end

  assign adc2_power_o = adc2_pwr_q;
  assign adc3_power_o = adc3_pwr_q;
  assign sinc_en_o = sinc_q;
  assign hpf_on_o = hpf_on_q;
  assign hpf_corner_o = hpf_corner_q;

  // ---------------------------------------------------------------
  // microphone capture and decimator source
  // ---------------------------------------------------------------
  aipc_mic_capture u_mic (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .mic_clk_i(mic_clk_i),
    .mic_data_i(mic_data_i),
    .swap_i(pair23_q[BIT_MIC_SWAP]),
    .pol_i(pair23_q[BIT_MIC_POL]),
    .left_bit_o(mic_l_bit),
    .left_valid_o(mic_l_vld),
    .right_bit_o(mic_r_bit),
    .right_valid_o(mic_r_vld)
  );

  // left feeds decimator 2, right feeds 3; strobes die with the sinc
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      dec2_bit_q <= 1'b0;
      dec2_vld_q <= 1'b0;
      dec3_bit_q <= 1'b0;
      dec3_vld_q <= 1'b0;
    end
    else if (pair23_q[BIT_DEC_SRC])
    begin
      dec2_bit_q <= mic_l_bit;
      dec2_vld_q <= mic_l_vld & decim_pwr_q[SINC2_BIT];
      dec3_bit_q <= mic_r_bit;
      dec3_vld_q <= mic_r_vld & decim_pwr_q[SINC3_BIT];
    end
    else
    begin
      dec2_bit_q <= adc2_mod_i;
      dec2_vld_q <= adc_mod_valid_i & adc2_pwr_q;
      dec3_bit_q <= adc3_mod_i;
      dec3_vld_q <= adc_mod_valid_i & adc3_pwr_q;
    end
  end

  assign dec2_bit_o = dec2_bit_q;
  assign dec2_valid_o = dec2_vld_q;
  assign dec3_bit_o = dec3_bit_q;
  assign dec3_valid_o = dec3_vld_q;

  // ---------------------------------------------------------------
  // amplifier 0 power, mute and gain slewing
  // ---------------------------------------------------------------

  // slewing only matters while powered, unmuted and off target
  assign amp_slewing = amp0_q[BIT_AMP_MIC] & ~amp0_q[BIT_AMP_MUTE] & (amp_eff_q != amp0_q[5:0]);
  assign amp_step = amp_slewing & sample_tick_i & (amp_div_q == AMP_SLEW_LAST_SAMPLE);

  // slew divider in sample periods
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      amp_div_q <= 4'h0;
    else if (!amp_slewing)
      amp_div_q <= 4'h0;
    else if (sample_tick_i)
      amp_div_q <= amp_div_q + 4'h1;
  end

  // applied gain: frozen while muted, snaps when powered down
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      amp_eff_q <= 6'h00;
    else if (amp0_q[BIT_AMP_MUTE])
      amp_eff_q <= amp_eff_q;
    else if (!amp0_q[BIT_AMP_MIC])
      amp_eff_q <= amp0_q[5:0];
    else if (amp_step && amp_eff_q < amp0_q[5:0])
      amp_eff_q <= amp_eff_q + 6'h01;
    else if (amp_step)
      amp_eff_q <= amp_eff_q - 6'h01;
  end

  // power follows the mic-select bit; gain figure from applied code
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      amp_power_q <= 1'b0;
      amp_mute_q <= 1'b1;
      amp_qdb_q <= GAIN_MIN_QDB;
    end
    else
    begin
      amp_power_q <= amp0_q[BIT_AMP_MIC];
      amp_mute_q <= amp0_q[BIT_AMP_MUTE];
      amp_qdb_q <= amp_gain_qdb(amp_eff_q);
    end
  end

  assign amp0_power_o = amp_power_q;
  assign amp0_mute_o = amp_mute_q;
  assign amp0_gain_code_o = amp_eff_q;
  assign amp0_gain_qdb_o = amp_qdb_q;
endmodule

// file: rtl/aipc_vol_ramp.sv
`timescale 1ns/1ns
module aipc_vol_ramp (
  input wire logic clk_i, // system clock
  input wire logic rst_n_i, // async reset, active low
  input wire logic sinc_en_i, // decimator sinc enable
  input wire logic sample_tick_i, // one pulse per sample period
  input wire logic [7:0] target_i, // programmed volume code
  output logic [7:0] vol_o, // live volume code
  output logic ramping_o // ramp in progress
);
  import aipc_pkg::*;

  aipc_ramp_state_type state_q;
  logic [7:0] vol_q;
  logic [3:0] div_q;
  logic step_now;

  // one step only after sixteen whole sample periods
  assign step_now = (state_q == RAMP_RUN) && sample_tick_i && (div_q == RAMP_LAST_SAMPLE);
  assign vol_o = vol_q;
  assign ramping_o = (state_q == RAMP_RUN);

  // ramp sequencing; a target change after settling ramps again
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      state_q <= RAMP_OFF;
    else if (!sinc_en_i)
      state_q <= RAMP_OFF;
    else
    begin
      case (state_q)
        RAMP_OFF: state_q <= RAMP_RUN;
        RAMP_RUN: if (vol_q == target_i) state_q <= RAMP_SETTLED;
        RAMP_SETTLED: if (vol_q != target_i) state_q <= RAMP_RUN;
        default: state_q <= RAMP_OFF;
      endcase
    end
  end

  // sample divider, restarted whenever the ramp is not running
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      div_q <= 4'h0;
    else if (state_q != RAMP_RUN)
      div_q <= 4'h0;
    else if (sample_tick_i)
      div_q <= div_q + 4'h1;
  end

  // held at full attenuation while off, so every enable starts quiet
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      vol_q <= VOL_FULL_ATTEN;
    else if (!sinc_en_i)
      vol_q <= VOL_FULL_ATTEN;
    else if (step_now && vol_q > target_i)
      vol_q <= vol_q - 8'h01;
    else if (step_now && vol_q < target_i)
      vol_q <= vol_q + 8'h01;
  end
endmodule

// file: verification/aipc_asserts.sv
`timescale 1ns/1ns
module aipc_asserts (
  input wire logic clk_i, // clock
  input wire logic rst_n_i, // reset
  input wire logic hsel_i, // select
  input wire logic [1:0] htrans_i, // transfer type
  input wire logic hwrite_i, // direction
  input wire logic hready_i, // bus ready
  input wire logic hreadyout_o, // slave ready
  input wire logic hresp_o, // response
  input wire logic adc2_power_o, // converter 2 power
  input wire logic [3:0] sinc_en_o, // sinc enables
  input wire logic hpf_on_o, // filter on
  input wire logic [1:0] hpf_corner_o, // corner
  input wire logic [3:0][7:0] ch_volume_o, // live volumes
  input wire logic [3:0][9:0] ch_atten_o, // attenuation
  input wire logic amp0_mute_o, // amp mute
  input wire logic [5:0] amp0_gain_code_o, // gain code
  input wire logic signed [8:0] amp0_gain_qdb_o // gain
);
  // ------------------------------
  // bus and register relations
  // ------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  wire logic taken = hsel_i & htrans_i[1] & hready_i;

  bus_okay_a: assert property (hresp_o == 1'b0) else $error("response not okay");
  read_wait_a: assert property (taken && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
    else $error("read wait state wrong");
  write_nowait_a: assert property (taken && hwrite_i |=> hreadyout_o) else $error("write stalled");
  adc_gate_a: assert property (adc2_power_o |-> sinc_en_o[2]) else $error("power without sinc");
  hpf_code_a: assert property (hpf_on_o == (hpf_corner_o != 2'h0)) else $error("filter on wrong");
  // attenuation lags the live code by one cycle, so skip the first edge after reset
  atten_scale_a: assert property ($past(rst_n_i) |-> ch_atten_o[1] == 10'(3 * $past(ch_volume_o[1])))
    else $error("attenuation scale wrong");
  ramp_start_a: assert property ($rose(sinc_en_o[1]) |-> ch_volume_o[1] == 8'hff)
    else $error("ramp not from full attenuation");
  ramp_pace_a: assert property ($changed(ch_volume_o[1]) && sinc_en_o[1] |=>
    (!sinc_en_o[1] || $stable(ch_volume_o[1]))[*8]) else $error("ramp too fast");
  gain_map_a: assert property ($past(rst_n_i) |->
    amp0_gain_qdb_o == -9'sd48 + 9'sd3 * $signed({3'h0, $past(amp0_gain_code_o)})) else $error("gain map wrong");
  mute_hold_a: assert property (amp0_mute_o && $past(amp0_mute_o) |-> $stable(amp0_gain_code_o))
    else $error("gain moved while muted");

  c_read: cover property (taken && !hwrite_i);
  c_ramp: cover property ($rose(sinc_en_o[1]));
  c_gain: cover property ($changed(amp0_gain_code_o));
endmodule

bind aipc_top aipc_asserts u_aipc_asserts (.clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i),
  .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i), .hreadyout_o(hreadyout_o),
  .hresp_o(hresp_o), .adc2_power_o(adc2_power_o), .sinc_en_o(sinc_en_o), .hpf_on_o(hpf_on_o),
  .hpf_corner_o(hpf_corner_o), .ch_volume_o(ch_volume_o), .ch_atten_o(ch_atten_o),
  .amp0_mute_o(amp0_mute_o), .amp0_gain_code_o(amp0_gain_code_o), .amp0_gain_qdb_o(amp0_gain_qdb_o));

// file: verification/aipc_top_tb_top.sv
`timescale 1ns/1ns
module aipc_top_tb_top;
  import aipc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic hsel_i = 1'b0;
  logic [31:0] haddr_i = 32'h0;
  logic [1:0] htrans_i = 2'h0;
  logic hwrite_i = 1'b0;
  logic [2:0] hsize_i = 3'h2;
  logic [31:0] hwdata_i = 32'h0;
  logic sample_tick_i = 1'b0;
  logic mic_clk_i = 1'b0;
  logic mic_data_i = 1'b0;
  logic adc_mod_valid_i = 1'b0;
  logic adc2_mod_i = 1'b0;
  logic adc3_mod_i = 1'b0;
  logic [31:0] hrdata_o;
  logic hreadyout_o;
  logic hresp_o;
  logic dec2_bit_o;
  logic dec2_valid_o;
  logic dec3_bit_o;
  logic dec3_valid_o;
  logic adc2_power_o;
  logic adc3_power_o;
  logic [3:0] sinc_en_o;
  logic hpf_on_o;
  logic [1:0] hpf_corner_o;
  logic [3:0][7:0] ch_volume_o;
  logic [3:0][9:0] ch_atten_o;
  logic amp0_power_o;
  logic amp0_mute_o;
  logic [5:0] amp0_gain_code_o;
  logic signed [8:0] amp0_gain_qdb_o;
  wire logic hready_i = hreadyout_o; // single slave drives the bus ready
  int n_fail = 0;
  int tests_run = 0;
  int n;
  logic [31:0] rd;

  // ------------------------------
  // clock, sample tick, design
  // ------------------------------
  always #5 clk_i = ~clk_i;
  // a tick every other cycle keeps ramps short while staying a one-cycle pulse
  always @(posedge clk_i) sample_tick_i <= ~sample_tick_i;

  aipc_top u_aipc_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .sample_tick_i(sample_tick_i),
    .mic_clk_i(mic_clk_i), .mic_data_i(mic_data_i), .adc_mod_valid_i(adc_mod_valid_i),
    .adc2_mod_i(adc2_mod_i), .adc3_mod_i(adc3_mod_i), .dec2_bit_o(dec2_bit_o), .dec2_valid_o(dec2_valid_o),
    .dec3_bit_o(dec3_bit_o), .dec3_valid_o(dec3_valid_o), .adc2_power_o(adc2_power_o),
    .adc3_power_o(adc3_power_o), .sinc_en_o(sinc_en_o), .hpf_on_o(hpf_on_o), .hpf_corner_o(hpf_corner_o),
    .ch_volume_o(ch_volume_o), .ch_atten_o(ch_atten_o), .amp0_power_o(amp0_power_o),
    .amp0_mute_o(amp0_mute_o), .amp0_gain_code_o(amp0_gain_code_o), .amp0_gain_qdb_o(amp0_gain_qdb_o));

  // ------------------------------
  // tasks
  // ------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one single transfer; called just after a rising edge, reads sample pre-edge values
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i <= {22'h0, idx, 2'h0};
    hwrite_i <= wr;
    @(posedge clk_i);
    while (hreadyout_o !== 1'b1) @(posedge clk_i);
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    @(posedge clk_i);
    while (hreadyout_o !== 1'b1) @(posedge clk_i);
    rd = hrdata_o;
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
    xfer(1'b0, idx, 32'h0);
    chk(rd, exp);
  endtask

  task automatic wait_dec;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk_i);
      if (dec2_valid_o === 1'b1 || dec3_valid_o === 1'b1) break;
    end
  endtask

  // one mic clock edge; expects the strobe on the side the edge and swap select
  task automatic mic(input logic lvl, input logic d, input logic sw, input logic pol);
    mic_data_i <= d;
    mic_clk_i <= lvl;
    wait_dec();
    chk({29'h0, dec2_valid_o, dec3_valid_o, dec2_valid_o ? dec2_bit_o : dec3_bit_o},
      {29'h0, lvl ^ sw, ~(lvl ^ sw), pol ? d : ~d});
  endtask

  // k below 4 waits on a live volume, k of 4 on the applied amplifier code
  task automatic wait_for(input int k, input logic [7:0] v);
    n = 0;
    while ((k < 4 ? ch_volume_o[k] : {2'h0, amp0_gain_code_o}) !== v && n < 9000)
    begin
      @(posedge clk_i);
      n++;
    end
    // a limit that runs out must count as a mismatch
    if (n >= 9000) chk(n, 32'h0);
  endtask

  task automatic conclude;
    $display("checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ------------------------------
  // test sequence
  // ------------------------------
  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    chk(ch_volume_o, 32'hffff_ffff);
    chk({22'h0, amp0_mute_o, amp0_gain_qdb_o}, {22'h0, 1'b1, 9'h1d0});
    rdchk(IDX_AMP0_CTRL, 32'h0000_0040);
    for (int k = 8'h1e; k < 8'h23; k++) rdchk(8'(k), 32'h0);
    // unmapped place or a byte-sized access swallows writes, reads zero
    xfer(1'b1, 8'h10, 32'hffff_ffff);
    rdchk(8'h10, 32'h0);
    hsize_i <= 3'h0;
    xfer(1'b1, IDX_CH0_VOL, 32'h0000_0055);
    hsize_i <= 3'h2;
    rdchk(IDX_CH0_VOL, 32'h0);
    xfer(1'b1, IDX_PAIR23_CTRL, 32'hffff_ff80);
    rdchk(IDX_PAIR23_CTRL, 32'h0000_0080);
    for (int c = 0; c < 4; c++)
    begin
      xfer(1'b1, IDX_PAIR23_CTRL, {25'h0, 2'(c), 5'h0});
      repeat (2) @(posedge clk_i);
      chk({29'h0, hpf_on_o, hpf_corner_o}, {29'h0, c != 0, 2'(c)});
    end
    // every mix of converter enable and sinc enable for both converters
    for (int c = 0; c < 16; c++)
    begin
      xfer(1'b1, IDX_PAIR23_CTRL, {30'h0, c[1:0]});
      xfer(1'b1, IDX_DECIM_PWR, {28'h0, c[3:2], 2'h0});
      repeat (2) @(posedge clk_i);
      chk({30'h0, adc3_power_o, adc2_power_o}, {30'h0, c[1:0] & c[3:2]});
    end
    adc2_mod_i <= 1'b1;
    adc_mod_valid_i <= 1'b1;
    @(posedge clk_i);
    adc_mod_valid_i <= 1'b0;
    wait_dec();
    chk({28'h0, dec2_valid_o, dec2_bit_o, dec3_valid_o, dec3_bit_o}, 32'h0000_000e);
    for (int m = 0; m < 4; m++)
    begin
      xfer(1'b1, IDX_PAIR23_CTRL, {27'h0, m[1], m[0], 1'b1, 2'h3});
      mic(1'b1, 1'b1, m[0], m[1]);
      mic(1'b0, 1'b0, m[0], m[1]);
    end
    // short ramp on channel 1: three steps, spacing of 16 ticks
    xfer(1'b1, IDX_CH1_VOL, 32'h0000_00fc);
    chk(ch_volume_o[1], 32'h0000_00ff);
    xfer(1'b1, IDX_DECIM_PWR, 32'h0000_000e);
    wait_for(1, 8'hfe);
    wait_for(1, 8'hfd);
    chk(n, 32'h0000_0020);
    wait_for(1, 8'hfc);
    repeat (40) @(posedge clk_i);
    chk({14'h0, ch_atten_o[1], ch_volume_o[1]}, {14'h0, 10'h2f4, 8'hfc});
    rdchk(8'h33, 32'h0000_00fc);
    // ch1 settled, ch0 off, ch2/3 still ramping, both converters powered
    rdchk(IDX_STATUS, 32'h0000_003c);
    // full range on channel 0: 255 steps of 32 cycles
    xfer(1'b1, IDX_DECIM_PWR, 32'h0000_000f);
    wait_for(0, 8'h00);
    chk(32'(n > 8150 && n < 8175), 32'h1);
    repeat (2) @(posedge clk_i);
    chk({22'h0, ch_atten_o[0]}, 32'h0);
    // amplifier: muted gain ignored, line mode snaps, mic mode slews
    xfer(1'b1, IDX_AMP0_CTRL, 32'h0000_007f);
    repeat (40) @(posedge clk_i);
    chk({26'h0, amp0_gain_code_o}, 32'h0);
    xfer(1'b1, IDX_AMP0_CTRL, 32'h0000_003f);
    repeat (3) @(posedge clk_i);
    chk({15'h0, amp0_power_o, amp0_mute_o, amp0_gain_code_o, amp0_gain_qdb_o}, {17'h0, 6'h3f, 9'h08d});
    xfer(1'b1, IDX_AMP0_CTRL, 32'h0000_0010);
    repeat (3) @(posedge clk_i);
    chk({23'h0, amp0_gain_qdb_o}, 32'h0);
    xfer(1'b1, IDX_AMP0_CTRL, 32'h0000_0092);
    wait_for(4, 8'h12);
    chk({30'h0, amp0_power_o, 1'(n > 60 && n < 70)}, 32'h3);
    conclude();
  end

  // ------------------------------
  // watchdog, about four and a half times the expected run
  // ------------------------------
  initial
  begin
    #400000;
    n_fail++;
    conclude();
  end
endmodule
